// >>> rtl/busoff_recovery.sv
// counts runs of eleven recessive bits while the node is bus-off
// assumes one sample strobe per bus bit time from the bit engine
module busoff_recovery
  import can_txerr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic active_in, // bus-off in force
  input wire logic bit_strobe_in, // one bus bit sampled
  input wire logic bit_recessive_in, // sampled level is recessive
  output logic done_out // pulse: all sequences seen
);
  recov_t state;
  recov_t next_state;
  logic next_done;

  // run and sequence counting
  always_comb
  begin
    next_state = state;
    next_done = 1'b0;
    if (!active_in)
    begin
      next_state = '0;
    end
    else if (bit_strobe_in)
    begin
      if (!bit_recessive_in)
      begin
        next_state.run = 4'h0; // dominant bit breaks the run
      end
      else if (state.run == RECESSIVE_RUN_BITS - 4'h1)
      begin
        next_state.run = 4'h0; // one full run seen
        if (state.seq == RECOVERY_SEQUENCES - 8'h01)
        begin
          next_state.seq = 8'h00;
          next_done = 1'b1;
        end
        else
        begin
          next_state.seq = state.seq + 8'h01;
        end
      end
      else
      begin
        next_state.run = state.run + 4'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state <= '0;
      done_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      done_out <= next_done;
    end
  end
endmodule

// >>> rtl/can_tx_error_and_mask_select.sv
// transmit error counter, one transmit buffer and filter mask select,
// behind an ahb-lite slave; assumes a bit engine outside that sends
// frames and reports errors and bus bit samples
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
module can_tx_error_and_mask_select
  import can_txerr_pkg::*;
#(
  parameter int DATA_BYTES = 8
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire ahb_req_t ahb_in,
  output ahb_rsp_t ahb_out,
  input wire logic [1:0] func_mode_in, // functional mode 0, 1 or 2
  input wire logic tx_error_in, // pulse: transmit error seen
  input wire logic tx_success_in, // pulse: frame sent on the bus
  input wire logic bit_strobe_in, // one bus bit sampled
  input wire logic bit_recessive_in, // sampled level is recessive
  output logic tx_start_out, // level: frame ready for the bit engine
  output tx_frame_t tx_frame_out, // frame contents
  output logic bus_off_out, // level: node off the bus
  output logic [1:0] filter0_mask_choice_out,
  output logic [1:0] filter1_mask_choice_out,
  output logic [1:0] filter2_mask_choice_out,
  output logic [1:0] filter3_mask_choice_out,
  output logic irq_out // level: unmasked status pending
);
  // all block state except the recovery counter's run and sequence counts
  typedef struct packed {
    logic [7:0] transmit_error_count;
    logic bus_off;
    logic tx_ctrl_req;
    logic [1:0] tx_prio;
    logic [7:0] tx_buffer0_ident_low;
    logic [7:0] tx_buffer0_ident_high;
    logic [7:0] tx_buffer0_ext_ident_low;
    logic [7:0] tx_buffer0_ext_ident_high;
    logic [3:0] dlc;
    logic [2:0] op_mode;
    logic [7:0] filter_mask_select_0;
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [DATA_BYTES-1:0][7:0] data;
    logic dp_valid; // data phase pending
    logic dp_write;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
  } state_t;

  state_t st;
  state_t nx;
  logic recov_done;
  logic [IRQ_BITS-1:0] irq_set;
  logic mode_sends;
  logic addr_phase;
  logic [31:0] rd_word;

  // mask select register present only in functional modes 1 and 2
  function automatic logic msel_present(input logic [1:0] fm);
    return (fm == 2'h1) || (fm == 2'h2);
  endfunction

  // data byte index decode: true when the address is the word of byte i
  function automatic logic data_hit(input logic [7:0] a, input int i);
    return a == (OFS_DATA_BASE + 8'(i * 4));
  endfunction

  // bus-off recovery counter
  busoff_recovery u_recovery (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .active_in(st.bus_off),
    .bit_strobe_in(bit_strobe_in),
    .bit_recessive_in(bit_recessive_in),
    .done_out(recov_done)
  );

  assign mode_sends = (st.op_mode == MODE_NORMAL) || (st.op_mode == MODE_LOOPBACK);
  assign addr_phase = ahb_in.hsel && ahb_in.hready && (ahb_in.htrans == HTRANS_NONSEQ);

  // read mux for the address being read
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (ahb_in.haddr[7:0])
      OFS_TX_ERROR_COUNT: rd_word = {24'h0, st.transmit_error_count};
      OFS_TX_CONTROL: rd_word = {28'h0, st.tx_ctrl_req, 1'b0, st.tx_prio};
      OFS_IDENT_LOW: rd_word = {24'h0, st.tx_buffer0_ident_low};
      OFS_IDENT_HIGH: rd_word = {24'h0, st.tx_buffer0_ident_high};
      OFS_EXT_IDENT_LOW: rd_word = {24'h0, st.tx_buffer0_ext_ident_low};
      OFS_EXT_IDENT_HIGH: rd_word = {24'h0, st.tx_buffer0_ext_ident_high};
      OFS_DATA_LENGTH: rd_word = {28'h0, st.dlc};
      OFS_MODE: rd_word = {28'h0, st.bus_off, st.op_mode};
      OFS_FILTER_MASK_SEL:
      begin
        // absent register reads zero
        if (msel_present(func_mode_in))
        begin
          rd_word = {24'h0, st.filter_mask_select_0};
        end
      end
      OFS_IRQ_STATUS: rd_word = {29'h0, st.irq_status};
      OFS_IRQ_MASK: rd_word = {29'h0, st.irq_mask};
      default:
      begin
        for (int i = 0; i < DATA_BYTES; i++)
        begin
          if (data_hit(ahb_in.haddr[7:0], i))
          begin
            rd_word = {24'h0, st.data[i]};
          end
        end
      end
    endcase
  end

  // next-state logic
  always_comb
  begin
    nx = st;
    irq_set = '0;
    // capture address phase; data phase follows with zero wait
    nx.dp_valid = addr_phase;
    nx.dp_write = ahb_in.hwrite;
    nx.dp_addr = ahb_in.haddr[7:0];
    if (addr_phase && !ahb_in.hwrite)
    begin
      nx.rdata = rd_word;
    end

    // error counting and bus-off entry
    if (tx_error_in && !st.bus_off)
    begin
      if (st.transmit_error_count == 8'hFF)
      begin
        nx.bus_off = 1'b1;
        irq_set[IRQ_BUS_OFF] = 1'b1;
      end
      else
      begin
        nx.transmit_error_count = st.transmit_error_count + 8'h01;
      end
    end
    // recovery after enough recessive runs
    if (recov_done)
    begin
      nx.transmit_error_count = 8'h00;
      nx.bus_off = 1'b0;
      irq_set[IRQ_RECOVERED] = 1'b1;
    end

    // register writes in the data phase
    if (st.dp_valid && st.dp_write)
    begin
      case (st.dp_addr)
        OFS_TX_CONTROL:
        begin
          nx.tx_ctrl_req = ahb_in.hwdata[TX_REQ_BIT];
          nx.tx_prio = ahb_in.hwdata[1:0];
        end
        OFS_IDENT_LOW: nx.tx_buffer0_ident_low = ahb_in.hwdata[7:0];
        OFS_IDENT_HIGH: nx.tx_buffer0_ident_high = ahb_in.hwdata[7:0];
        OFS_EXT_IDENT_LOW: nx.tx_buffer0_ext_ident_low = ahb_in.hwdata[7:0];
        OFS_EXT_IDENT_HIGH: nx.tx_buffer0_ext_ident_high = ahb_in.hwdata[7:0];
        OFS_DATA_LENGTH: nx.dlc = ahb_in.hwdata[3:0];
        OFS_MODE: nx.op_mode = ahb_in.hwdata[2:0];
        OFS_FILTER_MASK_SEL:
        begin
          // writes dropped when the register is absent
          if (msel_present(func_mode_in))
          begin
            nx.filter_mask_select_0 = ahb_in.hwdata[7:0];
          end
        end
        OFS_IRQ_STATUS: nx.irq_status = st.irq_status & ~ahb_in.hwdata[IRQ_BITS-1:0];
        OFS_IRQ_MASK: nx.irq_mask = ahb_in.hwdata[IRQ_BITS-1:0];
        default:
        begin
          for (int i = 0; i < DATA_BYTES; i++)
          begin
            if (data_hit(st.dp_addr, i))
            begin
              nx.data[i] = ahb_in.hwdata[7:0];
            end
          end
        end
      endcase
    end

    // completion clears the request; wins over a same-cycle write
    if (tx_success_in && st.tx_ctrl_req)
    begin
      nx.tx_ctrl_req = 1'b0;
      irq_set[IRQ_TX_DONE] = 1'b1;
    end

    // sticky status: set wins over clear
    nx.irq_status = nx.irq_status | irq_set;
  end

  // state register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st <= '0;
      st.op_mode <= MODE_RESET;
      st.filter_mask_select_0 <= FILTER_MASK_SEL_RESET;
    end
    else
    begin
      st <= nx;
    end
  end

  // request reaches the bit engine only in sending modes, off bus-off
  assign tx_start_out = st.tx_ctrl_req && mode_sends && !st.bus_off;

  // frame assembly; extended fields zeroed for standard frames
  always_comb
  begin
    tx_frame_out.std_ident = {st.tx_buffer0_ident_high,
                              st.tx_buffer0_ident_low[7:STD_LOW_LSB]};
    tx_frame_out.ext_en = st.tx_buffer0_ident_low[EXT_IDENT_EN_BIT];
    tx_frame_out.ext_ident = 18'h00000;
    if (tx_frame_out.ext_en)
    begin
      tx_frame_out.ext_ident = {st.tx_buffer0_ident_low[1:0],
                                st.tx_buffer0_ext_ident_high,
                                st.tx_buffer0_ext_ident_low};
    end
    else
    begin
      tx_frame_out.ext_ident = 18'h00000;
    end
    tx_frame_out.dlc = st.dlc;
    tx_frame_out.data = st.data;
  end

  // filter mask choice fields, two bits per filter
  assign filter0_mask_choice_out = st.filter_mask_select_0[1:0];
  assign filter1_mask_choice_out = st.filter_mask_select_0[3:2];
  assign filter2_mask_choice_out = st.filter_mask_select_0[5:4];
  assign filter3_mask_choice_out = st.filter_mask_select_0[7:6];

  assign bus_off_out = st.bus_off;
  assign irq_out = |(st.irq_status & st.irq_mask);

  // zero-wait okay slave
  assign ahb_out.hrdata = st.rdata;
  assign ahb_out.hreadyout = 1'b1;
  assign ahb_out.hresp = 1'b0;
endmodule

// >>> rtl/can_txerr_pkg.sv
// package for the transmit error / transmit buffer / mask select block
// assumes a 32-bit ahb-lite register bus, one word per register
package can_txerr_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_TX_ERROR_COUNT = 8'h00;
  localparam logic [7:0] OFS_TX_CONTROL = 8'h04;
  localparam logic [7:0] OFS_IDENT_LOW = 8'h08;
  localparam logic [7:0] OFS_IDENT_HIGH = 8'h0C;
  localparam logic [7:0] OFS_EXT_IDENT_LOW = 8'h10;
  localparam logic [7:0] OFS_EXT_IDENT_HIGH = 8'h14;
  localparam logic [7:0] OFS_DATA_LENGTH = 8'h18;
  localparam logic [7:0] OFS_MODE = 8'h1C;
  localparam logic [7:0] OFS_FILTER_MASK_SEL = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFS_DATA_BASE = 8'h40;
  // field positions
  localparam int TX_REQ_BIT = 3;
  localparam int EXT_IDENT_EN_BIT = 3;
  localparam int STD_LOW_LSB = 5;
  // reset values
  localparam logic [7:0] FILTER_MASK_SEL_RESET = 8'h50;
  localparam logic [2:0] MODE_RESET = 3'h4;
  // bus-off recovery counts
  localparam logic [3:0] RECESSIVE_RUN_BITS = 4'hB;
  localparam logic [7:0] RECOVERY_SEQUENCES = 8'h80;
  // operating modes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_LOOPBACK = 3'h2;
  localparam logic [2:0] MODE_CONFIG = 3'h4;
  // interrupt status bit positions
  localparam int IRQ_TX_DONE = 0;
  localparam int IRQ_BUS_OFF = 1;
  localparam int IRQ_RECOVERED = 2;
  localparam int IRQ_BITS = 3;
  // ahb htrans codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ahb-lite slave side signals
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_rsp_t;

  // frame handed to the bit engine
  typedef struct packed {
    logic [10:0] std_ident;
    logic ext_en;
    logic [17:0] ext_ident;
    logic [3:0] dlc;
    logic [63:0] data;
  } tx_frame_t;

  // bus-off recovery counter state
  typedef struct packed {
    logic [3:0] run;
    logic [7:0] seq;
  } recov_t;
endpackage

// >>> verification/can_bus_model.sv
// stand-in for the bit engine and the other nodes on the bus
// assumes tx_start_in comes from the block; drives change after a rising edge
module can_bus_model
(
  input wire logic clk_in,
  input wire logic tx_start_in,
  input wire logic [7:0] answer_delay_in,
  output logic tx_error_out,
  output logic tx_success_out,
  output logic bit_strobe_out,
  output logic bit_recessive_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // sends a frame only when asked, promptly or slowly
  initial
  begin
    tx_success_out = 1'b0;
    forever
    begin
      @(posedge clk_in);
      if (tx_start_in === 1'b1)
      begin
        repeat (answer_delay_in) @(posedge clk_in);
        tx_success_out <= 1'b1;
        @(posedge clk_in);
        tx_success_out <= 1'b0;
        @(posedge clk_in);
      end
    end
  end
  initial
  begin
    tx_error_out = 1'b0;
    bit_strobe_out = 1'b0;
    bit_recessive_out = 1'b0;
  end
  // a burst of transmit errors, one every other cycle
  task automatic errors(input int n);
    repeat (n)
    begin
      @(posedge clk_in);
      tx_error_out <= 1'b1;
      @(posedge clk_in);
      tx_error_out <= 1'b0;
    end
  endtask
  // one bit sample; the level line flips once the strobe is gone
  task automatic send_bit(input logic rec);
    @(posedge clk_in);
    bit_strobe_out <= 1'b1;
    bit_recessive_out <= rec;
    @(posedge clk_in);
    bit_strobe_out <= 1'b0;
    bit_recessive_out <= ~rec;
    repeat (2) @(posedge clk_in);
  endtask
  // runs of eleven recessive bits
  task automatic runs(input int n);
    repeat (n * 11) send_bit(1'b1);
  endtask
endmodule

// >>> verification/can_txerr_properties.sv
// port checks for the transmit error / mask select block
// assumes a bind into the design top, one clock domain
module can_txerr_properties
  import can_txerr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [1:0] func_mode_in,
  input wire logic tx_error_in,
  input wire logic tx_success_in,
  input wire logic bit_strobe_in,
  input wire logic bit_recessive_in,
  input wire logic tx_start_out,
  input wire logic bus_off_out,
  input wire logic [1:0] filter0_mask_choice_out,
  input wire logic [1:0] filter1_mask_choice_out,
  input wire logic [1:0] filter2_mask_choice_out,
  input wire logic [1:0] filter3_mask_choice_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic rec_strobe; // recessive bit sampled
  logic [7:0] sel; // all four mask fields
  logic [11:0] rec_seen; // recessive bits seen while off the bus
  assign rec_strobe = bit_strobe_in && bit_recessive_in;
  assign sel = {filter3_mask_choice_out, filter2_mask_choice_out,
    filter1_mask_choice_out, filter0_mask_choice_out};
  // saturating count, cleared while on the bus
  always_ff @(posedge clk_in)
  begin
    if (rst_in || !bus_off_out)
      rec_seen <= 12'h000;
    else if (rec_strobe && rec_seen != 12'hFFF)
      rec_seen <= rec_seen + 12'h001;
  end
  off_needs_error_a: assert property (
    $rose(bus_off_out) |-> $past(tx_error_in)) else $error("bus-off without error");
  off_no_start_a: assert property (
    bus_off_out |-> !tx_start_out) else $error("start while bus-off");
  on_stays_a: assert property (
    !bus_off_out && !tx_error_in |=> !bus_off_out) else $error("bus-off from nothing");
  exit_after_bit_a: assert property (
    $fell(bus_off_out) |-> $past(rec_strobe, 2) || $past(rec_strobe, 3) || $past(rec_strobe, 4))
    else $error("bus-off left without bit");
  exit_count_a: assert property (
    $fell(bus_off_out) |-> rec_seen >= 12'd1408) else $error("bus-off left early");
  done_drops_a: assert property (
    tx_start_out && tx_success_in |=> !tx_start_out) else $error("start held after send");
  mask_frozen_a: assert property (
    func_mode_in == 2'h0 ##1 func_mode_in == 2'h0 |-> $stable(sel))
    else $error("mask select moved in mode 0");
  reset_state_a: assert property (disable iff (1'b0)
    rst_in |=> sel == 8'h50 && !irq_out && !tx_start_out && !bus_off_out)
    else $error("reset state wrong");
endmodule

// >>> verification/testbench.sv
// self-checking bench for the transmit error / buffer / mask select block
// assumes the package, design, checker and bus model are compiled first
module testbench
  import can_txerr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [1:0] fmode = 2'h1; // functional mode
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [1:0] trans = 2'h0;
  logic wr = 1'b0;
  logic hsel_v = 1'b1; // slave select, held by the master
  logic [2:0] size = 3'h2; // whole-word transfers
  logic [7:0] delay = 8'h00; // model answer latency
  int mismatches = 0;
  int comparisons = 0;
  ahb_req_t req;
  ahb_rsp_t rsp;
  tx_frame_t frame;
  logic start, boff, irq, err, ok, stb, rec;
  logic [1:0] f0, f1, f2, f3;
  // one selected slave, hready from its own hreadyout
  assign req = '{hsel: hsel_v, haddr: addr, htrans: trans, hwrite: wr, hsize: size,
    hwdata: wdata, hready: rsp.hreadyout};
  can_tx_error_and_mask_select can_tx_error_and_mask_select_i (.clk_in(clk_in),
    .rst_in(rst_in), .ahb_in(req), .ahb_out(rsp), .func_mode_in(fmode),
    .tx_error_in(err), .tx_success_in(ok), .bit_strobe_in(stb), .bit_recessive_in(rec),
    .tx_start_out(start), .tx_frame_out(frame), .bus_off_out(boff),
    .filter0_mask_choice_out(f0), .filter1_mask_choice_out(f1),
    .filter2_mask_choice_out(f2), .filter3_mask_choice_out(f3), .irq_out(irq));
  can_bus_model can_bus_model_i (.clk_in(clk_in), .tx_start_in(start),
    .answer_delay_in(delay), .tx_error_out(err), .tx_success_out(ok),
    .bit_strobe_out(stb), .bit_recessive_out(rec));
  initial
  begin
    forever #25 clk_in = ~clk_in;
  end
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  // one single ahb transfer, waits for hready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk_in);
    trans <= HTRANS_NONSEQ;
    addr <= {24'h0, a};
    wr <= w;
    do @(posedge clk_in); while (rsp.hreadyout !== 1'b1);
    trans <= 2'h0;
    wdata <= d;
    do @(posedge clk_in); while (rsp.hreadyout !== 1'b1);
    r = rsp.hrdata;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
    // let the written register settle before outputs are looked at
    @(negedge clk_in);
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(n, r, e);
  endtask
  // reset values, read-only count, unmapped place, mask select gating
  task automatic t_regs();
    wreg(OFS_TX_ERROR_COUNT, 32'h55);
    rchk("error count", OFS_TX_ERROR_COUNT, 32'h0);
    rchk("mode", OFS_MODE, {29'h0, MODE_RESET});
    wreg(8'h3C, 32'hFF);
    rchk("unmapped", 8'h3C, 32'h0);
    rchk("mask select", OFS_FILTER_MASK_SEL, 32'h50);
    wreg(OFS_FILTER_MASK_SEL, 32'h1B);
    check("fields", {24'h0, f3, f2, f1, f0}, 32'h1B);
    fmode <= 2'h2;
    wreg(OFS_FILTER_MASK_SEL, 32'hE4);
    rchk("mask select 2", OFS_FILTER_MASK_SEL, 32'hE4);
    check("fields 2", {24'h0, f3, f2, f1, f0}, 32'hE4);
    fmode <= 2'h0;
    wreg(OFS_FILTER_MASK_SEL, 32'hFF);
    rchk("mask select 0", OFS_FILTER_MASK_SEL, 32'h0);
    check("fields 0", {24'h0, f3, f2, f1, f0}, 32'hE4);
    fmode <= 2'h1;
  endtask
  // load buffer, request in config, then send in the given mode
  task automatic t_frame(input logic [2:0] mode, input logic [7:0] dly);
    logic [31:0] r;
    int n;
    delay <= dly;
    for (int i = 0; i < 8; i++) wreg(OFS_DATA_BASE + 8'(4 * i), 32'(17 * (i + 1)));
    wreg(OFS_EXT_IDENT_LOW, 32'hFF);
    wreg(OFS_EXT_IDENT_HIGH, 32'hFF);
    wreg(OFS_IDENT_LOW, 32'h60);
    wreg(OFS_IDENT_HIGH, 32'h24);
    wreg(OFS_DATA_LENGTH, 32'h08);
    wreg(OFS_IRQ_MASK, 32'h7);
    wreg(OFS_MODE, {29'h0, MODE_CONFIG});
    wreg(OFS_TX_CONTROL, 32'h08);
    repeat (20) @(posedge clk_in);
    check("start in config", {31'h0, start}, 32'h0);
    check("ident", {21'h0, frame.std_ident}, 32'h123);
    check("ext enable", {31'h0, frame.ext_en}, 32'h0);
    check("ext ident", {14'h0, frame.ext_ident}, 32'h0);
    check("length", {28'h0, frame.dlc}, 32'h8);
    check("data low", frame.data[31:0], 32'h44332211);
    check("data high", frame.data[63:32], 32'h88776655);
    wreg(OFS_MODE, {29'h0, mode});
    if (dly > 8'd20) rchk("request held", OFS_TX_CONTROL, 32'h08);
    n = 0;
    do
    begin
      bus(1'b0, OFS_TX_CONTROL, 32'h0, r);
      n++;
    end
    while (r[TX_REQ_BIT] !== 1'b0 && n < 100);
    check("request done", r, 32'h0);
    rchk("status", OFS_IRQ_STATUS, 32'h1);
    check("irq on", {31'h0, irq}, 32'h1);
    wreg(OFS_IRQ_MASK, 32'h0);
    check("irq masked", {31'h0, irq}, 32'h0);
    wreg(OFS_IRQ_STATUS, 32'h1);
    rchk("status clear", OFS_IRQ_STATUS, 32'h0);
  endtask
  // overflow to bus-off, ignored errors, recovery by recessive runs
  task automatic t_bus_off();
    delay <= 8'd200;
    can_bus_model_i.errors(255);
    rchk("count full", OFS_TX_ERROR_COUNT, 32'hFF);
    check("on bus", {31'h0, boff}, 32'h0);
    can_bus_model_i.errors(2);
    rchk("count held", OFS_TX_ERROR_COUNT, 32'hFF);
    check("off bus", {31'h0, boff}, 32'h1);
    wreg(OFS_TX_CONTROL, 32'h08);
    check("no start", {31'h0, start}, 32'h0);
    repeat (10) can_bus_model_i.send_bit(1'b1);
    can_bus_model_i.send_bit(1'b0);
    can_bus_model_i.runs(127);
    check("still off", {31'h0, boff}, 32'h1);
    can_bus_model_i.runs(1);
    repeat (4) @(posedge clk_in);
    check("back on", {31'h0, boff}, 32'h0);
    rchk("count cleared", OFS_TX_ERROR_COUNT, 32'h0);
    rchk("status off", OFS_IRQ_STATUS, 32'h6);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge clk_in);
    mismatches++;
    stop_test();
  end
  initial
  begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_frame(MODE_NORMAL, 8'd0);
    t_frame(MODE_LOOPBACK, 8'd40);
    t_bus_off();
    stop_test();
  end
endmodule
bind can_tx_error_and_mask_select can_txerr_properties can_txerr_properties_i (.clk_in,
  .rst_in, .func_mode_in, .tx_error_in, .tx_success_in, .bit_strobe_in, .bit_recessive_in,
  .tx_start_out, .bus_off_out, .filter0_mask_choice_out, .filter1_mask_choice_out,
  .filter2_mask_choice_out, .filter3_mask_choice_out, .irq_out);
